// File: core/ssf_pkg.sv
// package: offsets, field positions, modes and flag carrier for the status flags
package ssf_pkg;
    // ==========================================================
    // bus widths and register offsets
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int CNT_W = 10;
    localparam logic [7:0] OFS_FIFO_MODE = 8'h28;
    localparam logic [7:0] OFS_FIFO_LEVEL = 8'h29;
    localparam logic [7:0] OFS_STATUS_MIRROR = 8'h44;
    // sample data windows that count as data reads
    localparam logic [7:0] DATA_A_LO = 8'h08;
    localparam logic [7:0] DATA_A_HI = 8'h0A;
    localparam logic [7:0] DATA_B_LO = 8'h0E;
    localparam logic [7:0] DATA_B_HI = 8'h17;
    // ==========================================================
    // field positions inside the status mirror
    localparam int BIT_MOTION = 4;
    localparam int BIT_OVERRUN = 3;
    localparam int BIT_LEVEL = 2;
    localparam int BIT_NONEMPTY = 1;
    localparam int BIT_NEWSAMPLE = 0;
    // ==========================================================
    // reset values
    localparam logic [1:0] RST_FIFO_MODE = 2'h0;
    localparam logic [7:0] RST_FIFO_LEVEL = 8'h00;
    localparam logic [7:0] RST_RDATA = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
    // ==========================================================
    // fifo policy selection
    typedef enum logic [1:0] {
        SSF_FIFO_OFF = 2'b00,
        SSF_FIFO_OLDEST = 2'b01,
        SSF_FIFO_STREAM = 2'b10,
        SSF_FIFO_TRIGGER = 2'b11
    } ssf_fifo_mode_e;
    // flag group carried as one word
    typedef struct packed {
        logic motion_over_threshold_flag;
        logic overrun_flag;
        logic queue_level_reached_flag;
        logic nonempty_flag;
        logic new_sample_flag;
    } ssf_flags_s;
    localparam ssf_flags_s FLAGS_RST = '{default: 1'b0};
endpackage : ssf_pkg

// File: core/ssf_status_flags.sv
// status flag bank: activity, fifo and new-sample flags behind a register port
// What this block does
// - a detected over-threshold motion sets the activity flag.
// - a fifo overrun sets the overrun flag and blocks fifo writes until a fifo read.
// - the overrun flag is produced only in the keep-oldest fifo policy.
// - the level flag is high while the fifo holds at least the programmed count.
// - the level flag rises one cycle after the fifo count reaches the programmed count.
// - the non-empty flag follows, one cycle late, whether the fifo holds a sample.
// - a fresh sample sets the new-sample flag, which stays low with nothing unread.
// - a host read of the sample data clears the new-sample flag.
// - the new-sample flag is never set while a sample data read is in progress.
// - a sample arriving during a read sets the flag only after the read ends.
// - a set new-sample flag is cleared at the very start of a data read.
// - with flag set and a sample during the read, clear, hold low, then set.
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ssf_status_flags (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_B,
    // register port
    input wire logic [ssf_pkg::ADDR_W-1:0] ADDR,
    input wire logic [ssf_pkg::DATA_W-1:0] WDATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    output logic [ssf_pkg::DATA_W-1:0] RDATA,
    // serial burst still open (read in progress)
    input wire logic BURST_HOLD,
    // events and state from the datapath
    input wire logic MOTION_EVENT,
    input wire logic SAMPLE_EVENT,
    input wire logic FIFO_OVERRUN_EVENT,
    input wire logic FIFO_POP,
    input wire logic [ssf_pkg::CNT_W-1:0] FIFO_COUNT,
    // outputs to datapath and observers
    output logic FIFO_WRITE_BLOCK,
    output ssf_pkg::ssf_flags_s FLAGS
);
    import ssf_pkg::*;

    // ==========================================================
    // address decode
    logic is_data_addr;
    logic data_rd;
    logic status_rd;
    logic mode_wr;
    logic level_wr;
    assign is_data_addr = ((ADDR >= DATA_A_LO) && (ADDR <= DATA_A_HI)) ||
                          ((ADDR >= DATA_B_LO) && (ADDR <= DATA_B_HI));
    assign data_rd = RD_STB && is_data_addr;
    assign status_rd = RD_STB && (ADDR == OFS_STATUS_MIRROR);
    // mirror has no write decode at all, so writes to it fall away
    assign mode_wr = WR_STB && (ADDR == OFS_FIFO_MODE);
    assign level_wr = WR_STB && (ADDR == OFS_FIFO_LEVEL);

    // ==========================================================
    // configuration registers
    ssf_fifo_mode_e mode_r;
    logic [DATA_W-1:0] level_r;
    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            mode_r <= SSF_FIFO_OFF;
            level_r <= RST_FIFO_LEVEL;
        end else begin
            if (mode_wr) begin
                mode_r <= ssf_fifo_mode_e'(WDATA[1:0]);
            end
            if (level_wr) begin
                level_r <= WDATA;
            end
        end
    end

    // ==========================================================
    // read-session tracking for the new-sample flag
    logic busy_r;
    logic busy_nxt;
    logic in_read;
    // a burst keeps the session open past the strobe cycle
    assign in_read = data_rd || busy_r;
    assign busy_nxt = in_read && BURST_HOLD;
    logic pend_r;
    logic pend_nxt;
    // samples during a read are parked, not lost
    assign pend_nxt = in_read && (pend_r || SAMPLE_EVENT);
    logic dr_r;
    logic dr_nxt;
    // start clears; held low through the read; set after it ends
    assign dr_nxt = data_rd ? 1'b0 :
                    in_read ? dr_r :
                    (dr_r || SAMPLE_EVENT || pend_r);

    // ==========================================================
    // fifo and activity flags; set wins over clear
    logic mot_r;
    logic mot_nxt;
    logic ovr_r;
    logic ovr_nxt;
    logic lvl_r;
    logic lvl_nxt;
    logic rdy_r;
    logic rdy_nxt;
    logic oldest;
    assign oldest = (mode_r == SSF_FIFO_OLDEST);
    // status read clears motion flag after the value has been sampled
    assign mot_nxt = MOTION_EVENT || (mot_r && !status_rd);
    // pop frees space; leaving keep-oldest withdraws the flag
    assign ovr_nxt = oldest && (FIFO_OVERRUN_EVENT ||
                     (ovr_r && !FIFO_POP));
    // registered compare on the incoming count, so the flag rises one cycle after the count reaches it
    assign lvl_nxt = (FIFO_COUNT >= {2'b00, level_r});
    assign rdy_nxt = (FIFO_COUNT != CNT_ZERO);

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            busy_r <= 1'b0;
            pend_r <= 1'b0;
            dr_r <= 1'b0;
            mot_r <= 1'b0;
            ovr_r <= 1'b0;
            lvl_r <= 1'b0;
            rdy_r <= 1'b0;
        end else begin
            busy_r <= busy_nxt;
            pend_r <= pend_nxt;
            dr_r <= dr_nxt;
            mot_r <= mot_nxt;
            ovr_r <= ovr_nxt;
            lvl_r <= lvl_nxt;
            rdy_r <= rdy_nxt;
        end
    end

    // ==========================================================
    // outputs and read data
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] rd_mux;
    assign status_word = {3'b000, mot_r, ovr_r, lvl_r, rdy_r, dr_r};
    // sample data itself lives in the datapath; those reads answer zero here
    assign rd_mux = (ADDR == OFS_STATUS_MIRROR) ? status_word :
                    (ADDR == OFS_FIFO_MODE) ? {6'b000000, mode_r} :
                    (ADDR == OFS_FIFO_LEVEL) ? level_r : RST_RDATA;
    logic [DATA_W-1:0] rdata_r;
    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            rdata_r <= RST_RDATA;
        end else begin
            rdata_r <= RD_STB ? rd_mux : RST_RDATA;
        end
    end
    assign RDATA = rdata_r;
    assign FIFO_WRITE_BLOCK = ovr_r;
    assign FLAGS = '{motion_over_threshold_flag: mot_r,
                     overrun_flag: ovr_r,
                     queue_level_reached_flag: lvl_r,
                     nonempty_flag: rdy_r,
                     new_sample_flag: dr_r};

    // ==========================================================
    // checks
    property p_motion_set;
        @(posedge CLK_SYS) disable iff (!RST_B)
        MOTION_EVENT |=> FLAGS.motion_over_threshold_flag;
    endproperty
    a_motion_set: assert property (p_motion_set)
        else $error("motion event did not set flag");

    property p_ovr_set;
        @(posedge CLK_SYS) disable iff (!RST_B)
        (FIFO_OVERRUN_EVENT && oldest) |=> (ovr_r && FIFO_WRITE_BLOCK);
    endproperty
    a_ovr_set: assert property (p_ovr_set)
        else $error("overrun did not set flag and block");

    property p_ovr_hold;
        @(posedge CLK_SYS) disable iff (!RST_B)
        (ovr_r && !FIFO_POP && oldest) |=> FIFO_WRITE_BLOCK;
    endproperty
    a_ovr_hold: assert property (p_ovr_hold)
        else $error("write block dropped without fifo read");

    property p_ovr_mode;
        @(posedge CLK_SYS) disable iff (!RST_B)
        $rose(ovr_r) |-> $past(mode_r == SSF_FIFO_OLDEST);
    endproperty
    a_ovr_mode: assert property (p_ovr_mode)
        else $error("overrun flag outside keep-oldest policy");

    property p_level;
        @(posedge CLK_SYS) disable iff (!RST_B)
        RST_B |=> (lvl_r == $past(FIFO_COUNT >= {2'b00, level_r}));
    endproperty
    a_level: assert property (p_level)
        else $error("level flag wrong for count");

    property p_nonempty;
        @(posedge CLK_SYS) disable iff (!RST_B)
        RST_B |=> (rdy_r == ($past(FIFO_COUNT) != CNT_ZERO));
    endproperty
    a_nonempty: assert property (p_nonempty)
        else $error("non-empty flag wrong for count");

    property p_sample_idle;
        @(posedge CLK_SYS) disable iff (!RST_B)
        (SAMPLE_EVENT && !in_read) |=> dr_r;
    endproperty
    a_sample_idle: assert property (p_sample_idle)
        else $error("idle sample did not set flag");

    property p_read_clear;
        @(posedge CLK_SYS) disable iff (!RST_B)
        data_rd |=> !dr_r;
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("data read did not clear flag");

    property p_no_set_busy;
        @(posedge CLK_SYS) disable iff (!RST_B)
        in_read |=> !$rose(dr_r);
    endproperty
    a_no_set_busy: assert property (p_no_set_busy)
        else $error("flag set during data read");

    sequence s_sample_in_read;
        in_read && (SAMPLE_EVENT || pend_r);
    endsequence
    sequence s_read_over;
        in_read ##1 !in_read;
    endsequence
    property p_set_after;
        @(posedge CLK_SYS) disable iff (!RST_B)
        (s_sample_in_read ##0 s_read_over) |=> dr_r;
    endproperty
    a_set_after: assert property (p_set_after)
        else $error("parked sample not delivered after read");

    // ==========================================================
    // further checks on the flags, the read session and the register port
    property p_ovr_release;
        @(posedge CLK_SYS) disable iff (!RST_B)
        (ovr_r && FIFO_POP && !FIFO_OVERRUN_EVENT) |=> !FIFO_WRITE_BLOCK;
    endproperty
    a_ovr_release: assert property (p_ovr_release)
        else $error("write block kept after fifo read");

    property p_ovr_policy;
        @(posedge CLK_SYS) disable iff (!RST_B)
        !oldest |=> !ovr_r;
    endproperty
    a_ovr_policy: assert property (p_ovr_policy)
        else $error("overrun flag held outside keep-oldest policy");

    // gated on sampled reset: the flags sit at zero on the first free edge
    property p_lvl_low;
        @(posedge CLK_SYS) disable iff (!RST_B)
        (RST_B && (FIFO_COUNT < {2'b00, level_r})) |=> !lvl_r;
    endproperty
    a_lvl_low: assert property (p_lvl_low)
        else $error("level flag high below threshold");

    property p_motion_hold;
        @(posedge CLK_SYS) disable iff (!RST_B)
        (FLAGS.motion_over_threshold_flag && !status_rd) |=>
            FLAGS.motion_over_threshold_flag;
    endproperty
    a_motion_hold: assert property (p_motion_hold)
        else $error("motion flag lost without status read");

    property p_dr_quiet;
        @(posedge CLK_SYS) disable iff (!RST_B)
        (RST_B && !SAMPLE_EVENT && !pend_r && !dr_r) |=> !dr_r;
    endproperty
    a_dr_quiet: assert property (p_dr_quiet)
        else $error("new-sample flag set with nothing unread");

    property p_park;
        @(posedge CLK_SYS) disable iff (!RST_B)
        (in_read && SAMPLE_EVENT) |=> (pend_r && !dr_r);
    endproperty
    a_park: assert property (p_park)
        else $error("sample during read not parked");

    property p_dr_hold;
        @(posedge CLK_SYS) disable iff (!RST_B)
        (RST_B && in_read && !data_rd) |=> $stable(dr_r);
    endproperty
    a_dr_hold: assert property (p_dr_hold)
        else $error("new-sample flag moved inside a read");

    property p_status_view;
        @(posedge CLK_SYS) disable iff (!RST_B)
        status_rd |=> (RDATA == $past(status_word));
    endproperty
    a_status_view: assert property (p_status_view)
        else $error("status read did not return the flags");

    property p_mirror_ro;
        @(posedge CLK_SYS) disable iff (!RST_B)
        (WR_STB && (ADDR == OFS_STATUS_MIRROR)) |=>
            ($stable(mode_r) && $stable(level_r));
    endproperty
    a_mirror_ro: assert property (p_mirror_ro)
        else $error("write to status mirror changed a setting");

    property p_reset_zero;
        @(posedge CLK_SYS)
        !RST_B |=> (FLAGS == FLAGS_RST);
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("flags not zero after reset");
endmodule : ssf_status_flags
`default_nettype wire

// File: verification/ssf_fifo_model.sv
// fifo occupancy model standing on the datapath side of the flag bank
`timescale 1ns/1ps
`default_nettype none
module ssf_fifo_model #(
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // pushes, pops and the write block
    input wire logic push,
    input wire logic pop,
    input wire logic block,
    // occupancy and overrun pulse
    output logic [9:0] count,
    output logic ovr
);
    // ==========================================================
    // a push at full is lost and pulses ovr; a blocked push is dropped
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            count <= 10'h000;
            ovr <= 1'h0;
        end else begin
            ovr <= push && count == DEPTH;
            if (pop && count != 0)
                count <= count - 10'h001;
            else if (push && !block && count != DEPTH)
                count <= count + 10'h001;
        end
    end
endmodule : ssf_fifo_model
`default_nettype wire

// File: verification/tb_top.sv
// self-checking bench for the status flag bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ssf_pkg::*;
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'h0;
    logic rd = 1'h0;
    logic hold = 1'h0;
    logic motion = 1'h0;
    logic sample = 1'h0;
    logic push = 1'h0;
    logic pop = 1'h0;
    logic ovr;
    logic blk;
    logic [7:0] rdata;
    logic [9:0] cnt;
    ssf_flags_s flags;
    int error_cnt = 0;
    int total_checks = 0;
    // ==========================================================
    // 100 MHz clock
    always #5 clk = ~clk;
    ssf_fifo_model ssf_fifo_model_i (.clk(clk), .rst_b(rst_b),
        .push(push), .pop(pop), .block(blk), .count(cnt), .ovr(ovr));
    ssf_status_flags ssf_status_flags_i (.CLK_SYS(clk), .RST_B(rst_b),
        .ADDR(addr), .WDATA(wdata), .WR_STB(wr), .RD_STB(rd),
        .RDATA(rdata), .BURST_HOLD(hold), .MOTION_EVENT(motion),
        .SAMPLE_EVENT(sample), .FIFO_OVERRUN_EVENT(ovr),
        .FIFO_POP(pop), .FIFO_COUNT(cnt), .FIFO_WRITE_BLOCK(blk),
        .FLAGS(flags));
    // ==========================================================
    // compare, wait and bus helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask : wr_reg
    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1;
        chk(rdata, exp);
    endtask : rd_chk
    // one-cycle event: 0 motion, 1 sample, 2 push, 3 pop
    task automatic pulse(input int w);
        @(posedge clk);
        motion <= (w == 0);
        sample <= (w == 1);
        push <= (w == 2);
        pop <= (w == 3);
        @(posedge clk);
        {motion, sample, push, pop} <= 4'h0;
        #1;
    endtask : pulse
    // ==========================================================
    // scenarios
    task automatic t_reset;
        tick(2);
        chk(8'(flags), 8'h04);
        wr_reg(OFS_STATUS_MIRROR, 8'hFF);
        tick(2);
        chk(8'(flags), 8'h04);
        rd_chk(8'h30, 8'h00);
        rd_chk(OFS_STATUS_MIRROR, 8'h04);
        $display("test reset done");
    endtask : t_reset
    task automatic t_motion;
        pulse(0);
        chk(8'(flags), 8'h14);
        rd_chk(OFS_STATUS_MIRROR, 8'h14);
        $display("test motion done");
    endtask : t_motion
    task automatic t_fifo;
        wr_reg(OFS_FIFO_LEVEL, 8'h02);
        wr_reg(OFS_FIFO_MODE, 8'h01);
        rd_chk(OFS_FIFO_MODE, 8'h01);
        rd_chk(OFS_FIFO_LEVEL, 8'h02);
        pulse(2);
        tick(1);
        chk(8'(flags), 8'h02);
        pulse(2);
        chk(8'(flags), 8'h02);
        tick(1);
        chk(8'(flags), 8'h06);
        pulse(2);
        pulse(2);
        pulse(2);
        tick(2);
        chk(8'(flags), 8'h0E);
        chk({7'h00, blk}, 8'h01);
        pulse(3);
        tick(1);
        chk(8'(flags), 8'h06);
        wr_reg(OFS_FIFO_MODE, 8'h02);
        pulse(2);
        pulse(2);
        tick(2);
        chk(8'(flags), 8'h06);
        wr_reg(OFS_FIFO_MODE, 8'h03);
        pulse(2);
        tick(2);
        chk(8'(flags), 8'h06);
        repeat (4) pulse(3);
        tick(1);
        chk(8'(flags), 8'h00);
        $display("test fifo done");
    endtask : t_fifo
    // data read kept open by the burst, a sample arriving inside it
    task automatic t_burst(input logic pre);
        if (pre)
            pulse(1);
        @(posedge clk);
        addr <= DATA_B_HI;
        rd <= 1'h1;
        hold <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        sample <= 1'h1;
        #1;
        chk(8'(flags), 8'h00);
        @(posedge clk);
        sample <= 1'h0;
        tick(3);
        chk(8'(flags), 8'h00);
        @(posedge clk);
        hold <= 1'h0;
        tick(3);
        chk(8'(flags), 8'h01);
        rd_chk(DATA_A_LO, 8'h00);
    endtask : t_burst
    task automatic t_sample;
        logic [7:0] da [4] = '{8'h08, 8'h0A, 8'h0E, 8'h17};
        pulse(1);
        chk(8'(flags), 8'h01);
        rd_chk(OFS_STATUS_MIRROR, 8'h01);
        chk(8'(flags), 8'h01);
        foreach (da[i]) begin
            pulse(1);
            rd_chk(da[i], 8'h00);
            chk(8'(flags), 8'h00);
        end
        t_burst(1'h0);
        t_burst(1'h1);
        // sample in the very cycle of a single data read
        pulse(1);
        @(posedge clk);
        addr <= DATA_A_LO;
        rd <= 1'h1;
        sample <= 1'h1;
        @(posedge clk);
        {rd, sample} <= 2'h0;
        #1;
        chk(8'(flags), 8'h00);
        tick(1);
        chk(8'(flags), 8'h01);
        $display("test sample done");
    endtask : t_sample
    // a reset in mid-run clears every flag and both settings
    task automatic t_rerun;
        pulse(0);
        chk(8'(flags), 8'h11);
        @(posedge clk);
        rst_b <= 1'h0;
        tick(3);
        chk(8'(flags), 8'h00);
        @(posedge clk);
        rst_b <= 1'h1;
        tick(1);
        chk(8'(flags), 8'h04);
        rd_chk(OFS_FIFO_MODE, 8'h00);
        rd_chk(OFS_FIFO_LEVEL, 8'h00);
        $display("test rerun done");
    endtask : t_rerun
    // ==========================================================
    // verdict, reached from the main sequence or the watchdog
    task automatic results;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results
    initial begin
        tick(10);
        chk(8'(flags), 8'h00);
        @(posedge clk);
        rst_b <= 1'h1;
        t_reset;
        t_motion;
        t_fifo;
        t_sample;
        t_rerun;
        results;
    end
    // the tests take about 140 cycles
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        results;
    end
endmodule : tb_top
`default_nettype wire
